// >>> lock_fault_pkg.sv
package lock_fault_pkg;

	localparam int unsigned CLK_PERIOD_NS = 4;
	// filter and retry timers share one 0.05 ms time base
	localparam int unsigned TICK_TIME_NS  = 50000;
	localparam int unsigned TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TICK_TIME_US  = TICK_TIME_NS / 1000;

	localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
	localparam int unsigned FIELD_W    = 4;
	localparam int unsigned THR_LSB    = 19;
	localparam int unsigned MODE_LSB   = 15;
	localparam int unsigned FILT_LSB   = 11;
	localparam int unsigned RETRY_LSB  = 7;

	localparam logic [3:0] MODE_FIRST_RETRY = 4'h4;
	localparam logic [3:0] MODE_REPORT      = 4'h8;
	localparam logic [3:0] MODE_FIRST_OFF   = 4'h9;
	localparam logic [3:0] THR_FIRST_RSVD   = 4'he;

	localparam int unsigned RETRY_FIRST_US = 500000;
	localparam int unsigned RETRY_STEP_US  = 1000000;
	localparam int unsigned RETRY_CNT_W    = 19;
	localparam int unsigned FILT_CNT_W     = 15;
	localparam int unsigned CURRENT_W      = 12;
	localparam int unsigned RETRY_LIMIT_W  = 3;

	typedef enum logic [2:0] {
		DRIVE_NORMAL  = 3'h0,
		DRIVE_HIZ     = 3'h1,
		DRIVE_RECIRC  = 3'h2,
		DRIVE_HS_BRK  = 3'h3,
		DRIVE_LS_BRK  = 3'h4
	} gate_drive_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'h0,
		ST_WAIT    = 2'h1,
		ST_LATCHED = 2'h3,
		ST_REPORT  = 2'h2
	} lock_state_t;

	// current in units of 1/128 A
	function automatic logic [CURRENT_W-1:0] lock_threshold(input logic [3:0] code);
		case (code)
			4'h0: lock_threshold = 12'h00a;
			4'h1: lock_threshold = 12'h014;
			4'h2: lock_threshold = 12'h028;
			4'h3: lock_threshold = 12'h050;
			4'h4: lock_threshold = 12'h078;
			4'h5: lock_threshold = 12'h0a0;
			4'h6: lock_threshold = 12'h0c8;
			4'h7: lock_threshold = 12'h0f0;
			4'h8: lock_threshold = 12'h118;
			4'h9: lock_threshold = 12'h140;
			4'ha: lock_threshold = 12'h168;
			4'hb: lock_threshold = 12'h190;
			4'hc: lock_threshold = 12'h1b8;
			4'hd: lock_threshold = 12'h1e0;
			default: lock_threshold = 12'hfff;
		endcase
	endfunction

	function automatic logic [FILT_CNT_W-1:0] filter_ticks(input logic [3:0] code);
		int unsigned us;
		case (code)
			4'h0: us = 50;
			4'h1: us = 100;
			4'h2: us = 200;
			4'h3: us = 500;
			4'h4: us = 1000;
			4'h5: us = 2500;
			4'h6: us = 5000;
			4'h7: us = 7500;
			4'h8: us = 10000;
			4'h9: us = 25000;
			4'ha: us = 50000;
			4'hb: us = 75000;
			4'hc: us = 100000;
			4'hd: us = 200000;
			4'he: us = 500000;
			default: us = 1000000;
		endcase
		filter_ticks = FILT_CNT_W'(us / TICK_TIME_US);
	endfunction

	// reserved code 0 runs as the shortest interval
	function automatic logic [RETRY_CNT_W-1:0] retry_ticks(input logic [3:0] code);
		int unsigned us;
		if (code <= 4'h1) begin
			us = RETRY_FIRST_US;
		end else begin
			us = (int'(code) - 1) * RETRY_STEP_US;
		end
		retry_ticks = RETRY_CNT_W'(us / TICK_TIME_US);
	endfunction

	function automatic gate_drive_t gate_action(input logic [3:0] mode);
		case (mode)
			4'h0, 4'h4: gate_action = DRIVE_HIZ;
			4'h1, 4'h5: gate_action = DRIVE_RECIRC;
			4'h2, 4'h6: gate_action = DRIVE_HS_BRK;
			4'h3, 4'h7: gate_action = DRIVE_LS_BRK;
			default:    gate_action = DRIVE_NORMAL;
		endcase
	endfunction

endpackage

// >>> lock_filter_if.sv
`timescale 1ns/1ps
interface lock_filter_if;
	logic       tick;
	logic       exceed;
	logic       restart;
	logic [3:0] code;
	logic       qualified;

	modport ctrl (output tick, output exceed, output restart, output code, input qualified);
	modport filt (input tick, input exceed, input restart, input code, output qualified);
endinterface

// >>> lock_filter.sv
`timescale 1ns/1ps
module lock_filter (
	input  wire logic    core_clk_in,
	input  wire logic    sys_rst_in,
	lock_filter_if.filt  bus
);
	import lock_fault_pkg::*;

	typedef struct packed {
		logic [FILT_CNT_W-1:0] cnt;
		logic                  qual;
	} filt_t;

	filt_t q_ff;
	filt_t nxt_q;
	logic [FILT_CNT_W-1:0] target;

	assign target = filter_ticks(bus.code);
	assign bus.qualified = q_ff.qual;

	always_comb begin
		nxt_q = q_ff;
		// any dip below threshold starts the wait over
		if (bus.restart || !bus.exceed) begin
			nxt_q.cnt  = '0;
			nxt_q.qual = 1'b0;
		end else if (bus.tick && !q_ff.qual) begin
			nxt_q.cnt = q_ff.cnt + 1'b1;
			// one tick more than the target: a partial first tick never counts
			if (q_ff.cnt + 1'b1 > target) begin
				nxt_q.qual = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_filter_drop: assert property (!bus.exceed |=> !bus.qualified)
		else $error("qualified without exceedance");
	a_filter_count: assert property ($rose(bus.qualified) |-> q_ff.cnt > filter_ticks(bus.code))
		else $error("qualified before filter time");
endmodule

// >>> lock_fault_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - modes 0h/1h latch, tristate or recirculate
// - modes 2h/3h latch, high or low brake
// - modes 4h/5h/7h retry, then latch
// - mode 6h high brake, bounded retries
// - mode 8h reports only, pin asserted
// - modes 9h and up disable detection
// - exceedance must persist for filter time
// - threshold 0.078125 A to 3.75 A, Eh/Fh reserved
// - retry interval 500 ms, then 1..14 s
module lock_fault_ctrl #(
	parameter int unsigned TICK_CYCLES = lock_fault_pkg::TICK_CYCLES
) (
	input  wire logic                                    core_clk_in,
	input  wire logic                                    sys_rst_in,
	input  wire logic                                    cfg_wr_in,
	input  wire logic [31:0]                             cfg_wdata_in,
	output logic      [31:0]                             cfg_rdata_out,
	input  wire logic [lock_fault_pkg::CURRENT_W-1:0]    lock_current_in,
	input  wire logic [lock_fault_pkg::RETRY_LIMIT_W-1:0] retry_count_limit_in,
	input  wire logic                                    fault_clear_in,
	output logic                                         fault_indicator_n_out,
	output lock_fault_pkg::gate_drive_t                  gate_drive_out,
	output logic                                         lock_fault_out,
	output logic      [lock_fault_pkg::RETRY_LIMIT_W-1:0] retry_used_out
);
	import lock_fault_pkg::*;

	localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic [31:0]              cfg;
		lock_state_t              st;
		gate_drive_t              gate;
		logic [RETRY_LIMIT_W-1:0] retries;
		logic [RETRY_CNT_W-1:0]   wait_cnt;
		logic [PW-1:0]            presc;
		logic                     tick;
		logic                     fault_n;
	} ctrl_t;

	ctrl_t q_ff;
	ctrl_t nxt_q;
	logic [3:0] mode;
	logic [3:0] thr_code;
	logic [3:0] retry_code;
	logic       qual;

	lock_filter_if lf ();

	lock_filter u_filter (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.bus         (lf.filt)
	);

	assign mode       = q_ff.cfg[MODE_LSB +: FIELD_W];
	assign thr_code   = q_ff.cfg[THR_LSB +: FIELD_W];
	assign retry_code = q_ff.cfg[RETRY_LSB +: FIELD_W];
	assign qual       = lf.qualified;

	assign lf.tick    = q_ff.tick;
	assign lf.code    = q_ff.cfg[FILT_LSB +: FIELD_W];
	// reserved threshold codes never trip, safer than a guess
	assign lf.exceed  = (thr_code < THR_FIRST_RSVD) &&
	                    (lock_current_in >= lock_threshold(thr_code));
	// filter restarts on every fault exit so a retry waits afresh;
	// report keeps it running so the pin follows the detection
	assign lf.restart = (q_ff.st != ST_IDLE && q_ff.st != ST_REPORT) ||
	                    (mode >= MODE_FIRST_OFF);

	assign cfg_rdata_out         = q_ff.cfg;
	assign fault_indicator_n_out = q_ff.fault_n;
	assign gate_drive_out        = q_ff.gate;
	assign lock_fault_out        = (q_ff.st == ST_LATCHED);
	assign retry_used_out        = q_ff.retries;

	always_comb begin
		nxt_q      = q_ff;
		nxt_q.tick = 1'b0;
		if (q_ff.presc == PW'(TICK_CYCLES - 1)) begin
			nxt_q.presc = '0;
			nxt_q.tick  = 1'b1;
		end else begin
			nxt_q.presc = q_ff.presc + 1'b1;
		end
		if (cfg_wr_in) begin
			nxt_q.cfg = cfg_wdata_in;
		end
		case (q_ff.st)
			ST_IDLE: begin
				nxt_q.gate    = DRIVE_NORMAL;
				nxt_q.fault_n = 1'b1;
				if (fault_clear_in) begin
					nxt_q.retries = '0;
				end
				if (qual && mode < MODE_FIRST_OFF) begin
					nxt_q.fault_n = 1'b0;
					nxt_q.gate    = gate_action(mode);
					if (mode == MODE_REPORT) begin
						nxt_q.st = ST_REPORT;
					end else if (mode < MODE_FIRST_RETRY) begin
						nxt_q.st = ST_LATCHED;
					end else if (q_ff.retries >= retry_count_limit_in) begin
						nxt_q.st = ST_LATCHED;
					end else begin
						nxt_q.st       = ST_WAIT;
						nxt_q.retries  = q_ff.retries + 1'b1;
						nxt_q.wait_cnt = retry_ticks(retry_code);
					end
				end
			end
			ST_WAIT: begin
				if (q_ff.tick) begin
					if (q_ff.wait_cnt == '0) begin
						nxt_q.st      = ST_IDLE;
						nxt_q.gate    = DRIVE_NORMAL;
						nxt_q.fault_n = 1'b1;
					end else begin
						nxt_q.wait_cnt = q_ff.wait_cnt - 1'b1;
					end
				end
			end
			ST_LATCHED: begin
				if (fault_clear_in) begin
					nxt_q.st      = ST_IDLE;
					nxt_q.retries = '0;
					nxt_q.gate    = DRIVE_NORMAL;
					nxt_q.fault_n = 1'b1;
				end
			end
			ST_REPORT: begin
				// report follows the detection, nothing to hold
				if (!qual || mode != MODE_REPORT) begin
					nxt_q.st      = ST_IDLE;
					nxt_q.fault_n = 1'b1;
				end
			end
			default: begin
				nxt_q.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			q_ff         <= '0;
			q_ff.cfg     <= CFG_RESET;
			q_ff.st      <= ST_IDLE;
			q_ff.gate    <= DRIVE_NORMAL;
			q_ff.fault_n <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_latch_tristate: assert property (q_ff.st == ST_IDLE && qual && mode < 4'h2
		|=> q_ff.st == ST_LATCHED && !fault_indicator_n_out &&
		    gate_drive_out == ($past(mode) == 4'h0 ? DRIVE_HIZ : DRIVE_RECIRC))
		else $error("modes 0h/1h did not latch");
	a_latch_brake: assert property (q_ff.st == ST_IDLE && qual && (mode == 4'h2 || mode == 4'h3)
		|=> q_ff.st == ST_LATCHED && !fault_indicator_n_out &&
		    gate_drive_out == ($past(mode) == 4'h2 ? DRIVE_HS_BRK : DRIVE_LS_BRK))
		else $error("modes 2h/3h did not brake");
	a_retry_bound: assert property (q_ff.st == ST_IDLE && qual && mode >= 4'h4 && mode <= 4'h7
		&& q_ff.retries >= retry_count_limit_in |=> q_ff.st == ST_LATCHED)
		else $error("retry limit not honoured");
	a_retry_step: assert property (q_ff.st == ST_IDLE && qual && mode >= 4'h4 && mode <= 4'h7
		&& q_ff.retries < retry_count_limit_in
		|=> q_ff.st == ST_WAIT && q_ff.retries == $past(q_ff.retries) + 3'h1)
		else $error("retry not started");
	a_wait_release: assert property (q_ff.st == ST_WAIT && q_ff.tick && q_ff.wait_cnt == '0
		|=> q_ff.st == ST_IDLE && fault_indicator_n_out && gate_drive_out == DRIVE_NORMAL)
		else $error("retry wait did not release");
	a_idle_normal: assert property (q_ff.st == ST_IDLE
		|-> gate_drive_out == DRIVE_NORMAL && fault_indicator_n_out)
		else $error("idle with protective drive");
	a_hs_retry: assert property (q_ff.st == ST_IDLE && qual && mode == 4'h6
		|=> gate_drive_out == DRIVE_HS_BRK && !fault_indicator_n_out)
		else $error("mode 6h not braking high");
	a_wait_drive: assert property (q_ff.st == ST_WAIT
		|-> !fault_indicator_n_out && gate_drive_out != DRIVE_NORMAL)
		else $error("retry wait without fault drive");
	a_report_only: assert property (q_ff.st == ST_REPORT
		|-> gate_drive_out == DRIVE_NORMAL && !fault_indicator_n_out)
		else $error("report mode acted on gates");
	a_report_hold: assert property (q_ff.st == ST_REPORT && qual && lf.exceed && mode == 4'h8
		|=> q_ff.st == ST_REPORT && qual)
		else $error("report dropped while detected");
	a_report_release: assert property (q_ff.st == ST_REPORT && !qual
		|=> q_ff.st == ST_IDLE && fault_indicator_n_out)
		else $error("report held without detection");
	a_lock_disabled: assert property (q_ff.st == ST_IDLE && mode >= 4'h9
		|=> q_ff.st == ST_IDLE && fault_indicator_n_out && gate_drive_out == DRIVE_NORMAL)
		else $error("disabled mode raised fault");
	a_disabled_no_qual: assert property (mode >= 4'h9
		|=> !qual)
		else $error("disabled mode qualified");
	a_thr_reserved: assert property (thr_code >= 4'he |-> !lf.exceed)
		else $error("reserved threshold tripped");
	a_retry_first: assert property (q_ff.st == ST_IDLE && qual && mode >= 4'h4 && mode <= 4'h7
		&& q_ff.retries < retry_count_limit_in && retry_code == 4'h1
		|=> q_ff.wait_cnt == 19'h02710)
		else $error("500 ms retry interval wrong");
	a_retry_last: assert property (q_ff.st == ST_IDLE && qual && mode >= 4'h4 && mode <= 4'h7
		&& q_ff.retries < retry_count_limit_in && retry_code == 4'hf
		|=> q_ff.wait_cnt == 19'h445c0)
		else $error("14 s retry interval wrong");
	a_latch_holds: assert property (q_ff.st == ST_LATCHED && !fault_clear_in
		|=> q_ff.st == ST_LATCHED && !fault_indicator_n_out && $stable(gate_drive_out))
		else $error("latched fault released without clear");
	a_clear_release: assert property (q_ff.st == ST_LATCHED && fault_clear_in
		|=> q_ff.st == ST_IDLE && fault_indicator_n_out && gate_drive_out == DRIVE_NORMAL &&
		    retry_used_out == 3'h0)
		else $error("clear did not release fault");

	c_latched: cover property (q_ff.st == ST_IDLE ##1 q_ff.st == ST_LATCHED);
	c_retry_back: cover property (q_ff.st == ST_WAIT ##1 q_ff.st == ST_IDLE);
	c_report: cover property (q_ff.st == ST_REPORT);
	c_cleared: cover property (q_ff.st == ST_LATCHED && fault_clear_in);
	c_hs_wait: cover property (q_ff.st == ST_WAIT && gate_drive_out == DRIVE_HS_BRK);
endmodule

// >>> motor_stage_model.sv
`timescale 1ns/1ps
module motor_stage_model (
	input  wire lock_fault_pkg::gate_drive_t gate_drive_in,
	input  wire logic [11:0]                 load_in,
	output logic      [11:0]                 current_out
);
	import lock_fault_pkg::*;
	// any protective state stops current flow, so a latch must hold on its own
	assign current_out = (gate_drive_in == DRIVE_NORMAL) ? load_in : 12'h000;
endmodule

// >>> lock_fault_ctrl_tb.sv
`timescale 1ns/1ps
module lock_fault_ctrl_tb;
	import lock_fault_pkg::*;
	logic        clk;
	logic        rst;
	logic        wr;
	logic [31:0] wd;
	logic [31:0] rd;
	logic [11:0] load;
	logic [11:0] cur;
	logic [2:0]  lim;
	logic        clr;
	logic        pin_n;
	gate_drive_t gate;
	logic        lf;
	logic [2:0]  used;
	logic [31:0] seed;
	int          bad_count;
	int          check_count;
	int          n;
	int          t;

	lock_fault_ctrl #(.TICK_CYCLES(4)) uut (
		.core_clk_in(clk), .sys_rst_in(rst), .cfg_wr_in(wr), .cfg_wdata_in(wd),
		.cfg_rdata_out(rd), .lock_current_in(cur), .retry_count_limit_in(lim),
		.fault_clear_in(clr), .fault_indicator_n_out(pin_n), .gate_drive_out(gate),
		.lock_fault_out(lf), .retry_used_out(used));
	motor_stage_model stage (.gate_drive_in(gate), .load_in(load), .current_out(cur));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] cfg(input logic [3:0] m, f, r, th);
		return {9'h000, th, m, f, r, 7'h00};
	endfunction
	function automatic logic [2:0] exp_gate(input int m);
		return (m < 8) ? 3'((m % 4) + 1) : 3'h0;
	endfunction
	function automatic int filt_ticks(input int c);
		int tb[5] = '{1, 2, 4, 10, 20};
		return tb[c];
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr_cfg(input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic set_load(input logic [11:0] v);
		@(posedge clk);
		load <= v;
	endtask
	// waits for the pin level; a forced wait that runs out ends the run
	task automatic wait_pin(input logic lvl, input int bound, input bit must);
		n = 0;
		@(negedge clk);
		while (pin_n !== lvl && n < bound) begin
			@(negedge clk);
			n++;
		end
		if (must && n >= bound) begin
			chk("wait", 0, 1);
			complete_run();
		end
	endtask
	task automatic clear_fault;
		set_load(12'h000);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		@(negedge clk);
	endtask

	initial begin
		rst = 1'b1;
		wr = 1'b0;
		wd = 32'h0;
		load = 12'h000;
		lim = 3'h0;
		clr = 1'b0;
		seed = 32'hd077;
		bad_count = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("rdata", rd, 32'h0);
		chk("pin", pin_n, 1'b1);
		chk("gate", gate, 3'h0);
		seed = xs(seed);
		wr_cfg(seed);
		@(negedge clk);
		chk("rdata", rd, seed);
		for (int m = 0; m < 16; m++) begin
			wr_cfg(cfg(m, 0, 1, 0));
			set_load(12'h0c8);
			wait_pin(1'b0, 40, m < 9);
			chk("pin", pin_n, m > 8);
			chk("gate", gate, exp_gate(m));
			chk("lock", lf, m < 8);
			repeat (20) @(negedge clk);
			chk("hold", pin_n, m > 8);
			set_load(12'h000);
			repeat (10) @(negedge clk);
			chk("drop", pin_n, m != 8 && m < 9 ? 1'b0 : 1'b1);
			clear_fault();
			chk("clear", {pin_n, gate}, 4'h8);
		end
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			t = filt_ticks(i == 0 ? 4 : seed % 5);
			wr_cfg(cfg(0, i == 0 ? 4 : seed % 5, 1, 0));
			set_load(12'h0c8);
			wait_pin(1'b0, 200, 1);
			chk("filt_min", n >= t * 4 + 2, 1'b1);
			chk("filt_max", n <= t * 4 + 5, 1'b1);
			clear_fault();
		end
		wr_cfg(cfg(0, 0, 1, 0));
		set_load(12'h009);
		wait_pin(1'b0, 40, 0);
		chk("thr0_low", pin_n, 1'b1);
		wr_cfg(cfg(0, 0, 1, 4'hd));
		set_load(12'h1df);
		wait_pin(1'b0, 40, 0);
		chk("thrd_low", pin_n, 1'b1);
		set_load(12'h1e0);
		wait_pin(1'b0, 40, 1);
		clear_fault();
		wr_cfg(cfg(0, 0, 1, 4'he));
		set_load(12'hfff);
		wait_pin(1'b0, 40, 0);
		chk("thr_rsvd", pin_n, 1'b1);
		@(posedge clk);
		lim <= 3'h1;
		wr_cfg(cfg(6, 0, 1, 0));
		set_load(12'h0c8);
		wait_pin(1'b0, 40, 1);
		chk("retry_gate", {lf, gate}, 4'h3);
		wait_pin(1'b1, 41000, 1);
		chk("retry_min", n >= 40000, 1'b1);
		chk("retry_max", n <= 40012, 1'b1);
		chk("used", used, 3'h1);
		wr_cfg(cfg(4, 0, 1, 0));
		wait_pin(1'b0, 40, 1);
		chk("retry_latch", {lf, gate}, 4'h9);
		clear_fault();
		chk("used_clr", used, 3'h0);
		complete_run();
	end
endmodule
